// ### hw/sbsc_regs.svh
/*
 offsets, field positions and reset values of the burst sram control block.
 assumes a 32-bit classic wishbone slave with byte addresses.
*/
`ifndef SBSC_REGS_SVH
`define SBSC_REGS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define SBSC_CFG_OFS      8'h00
`define SBSC_STAT_OFS     8'h04

// ----------------------------------------------------------------
// mode register fields
// ----------------------------------------------------------------
`define SBSC_CFG_LINEAR_N 0
`define SBSC_CFG_FLOW_N   1
`define SBSC_CFG_SLEEP    2
`define SBSC_CFG_SINGLE_DS 3
`define SBSC_CFG_W        4
// interleaved, pipelined, awake, single cycle deselect
`define SBSC_CFG_RST      4'hb

// ----------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------
`define SBSC_STAT_BADDR   0
`define SBSC_STAT_DRIVE   2
`define SBSC_STAT_ACTIVE  3
`define SBSC_STAT_SLEEP   4

// ----------------------------------------------------------------
// geometry
// ----------------------------------------------------------------
`define SBSC_LANE_W       9
`define SBSC_BURST_W      2

`endif

// ### hw/sbsc_pkg.sv
/*
 types shared by the burst sram control block.
 assumes the constants header is included where offsets are needed.
*/
package sbsc_pkg;

	// synchronous control pins sampled on each rising edge
	typedef struct packed {
		logic chip_select_n;
		logic processor_addr_strobe_n;
		logic cache_ctrl_addr_strobe_n;
		logic burst_step_n;
		logic all_bytes_write_n;
		logic byte_write_gate_n;
	} sbsc_ctl_t;

	// kind of cycle captured at an edge
	typedef enum logic [1:0] {
		SBSC_OP_NONE  = 2'b00,
		SBSC_OP_READ  = 2'b01,
		SBSC_OP_WRITE = 2'b10,
		SBSC_OP_DESEL = 2'b11
	} sbsc_op_t;

endpackage

// ### hw/sbsc_ctrl.sv
/*
 control logic of a synchronous burst sram: burst counter, byte-lane write
 decode, output drive pipeline with single/dual cycle deselect, sleep, and
 a classic wishbone slave holding the mode bits.
 assumes all pins synchronous to clock except output_enable_n.
*/
// Local design decisions: the register addresses and the Wishbone slave port.
// Operation
// - two low address bits form low address and preset the burst counter
// - each byte lane has its own active-low write enable
// - burst counter advances only while burst step is sampled low
// - processor or cache controller strobe, either low, loads a new address
// - chip select is active low; new access only when sampled low
// - output enable low-active, asynchronous; high forces drivers off
// - burst order: linear when low, interleaved when high
// - output register bypassed when flow-through select is low
// - sleep request high puts the device into standby
// - deselect depth low gives dual, high gives single cycle deselect
// - unset mode bits default to pipelined, single deselect, awake
// - linear order counts preset plus one modulo four, wraps on fifth
// - interleaved order is preset xor count, wraps on fifth clock
// - both global and byte write gate high means read, all lanes out
// - global write low writes every lane, ignoring other enables
// - byte write gate low writes exactly the lanes enabled low
// - data pins stay undriven during every write
// - the two upper lanes exist only in the wider organisation
// - a read with output enable high still advances the counter
`timescale 1ns/1ps
`include "sbsc_regs.svh"

module sbsc_ctrl #(
	parameter int LANES  = 4,
	parameter int HI_W   = 4
) (
	input  wire logic                           clock,
	input  wire logic                           rstn,
	input  wire sbsc_pkg::sbsc_ctl_t            ctl,
	input  wire logic [LANES-1:0]               lane_write_n,
	input  wire logic [`SBSC_BURST_W-1:0]       address_low_preset,
	input  wire logic [HI_W-1:0]                address_high,
	input  wire logic                           output_enable_n,
	input  wire logic [LANES*`SBSC_LANE_W-1:0]  dq_i,
	output logic      [LANES*`SBSC_LANE_W-1:0]  dq_o,
	output logic      [LANES-1:0]               dq_oe,
	input  wire logic                           wb_cyc_i,
	input  wire logic                           wb_stb_i,
	input  wire logic                           wb_we_i,
	input  wire logic [7:0]                     wb_adr_i,
	input  wire logic [3:0]                     wb_sel_i,
	input  wire logic [31:0]                    wb_dat_i,
	output logic      [31:0]                    wb_dat_o,
	output logic                                wb_ack_o
);

	localparam int DW    = LANES * `SBSC_LANE_W;
	localparam int AW    = HI_W + `SBSC_BURST_W;
	localparam int DEPTH = 1 << AW;

	// ----------------------------------------------------------------
	// elaboration checks
	// ----------------------------------------------------------------
	// narrow organisation has lanes a and b only, wide adds c and d
	if (LANES != 2 && LANES != 4) begin : g_bad_lanes
		$error("LANES must be 2 or 4");
	end
	if (HI_W < 1 || HI_W > 16) begin : g_bad_hi
		$error("HI_W must be 1 to 16");
	end

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [`SBSC_CFG_W-1:0]   cfg;
		logic [`SBSC_BURST_W-1:0] start;
		logic [`SBSC_BURST_W-1:0] cnt;
		logic [HI_W-1:0]          hi;
		logic                     active;
		logic                     drv1;
		logic                     drv2;
		logic [DW-1:0]            rd1;
		logic [DW-1:0]            rd2;
		logic                     ack;
		logic [31:0]              dat;
	} sbsc_state_t;

	sbsc_state_t        st_r;
	sbsc_state_t        st_nxt;
	logic [DW-1:0]      mem [DEPTH];

	// ----------------------------------------------------------------
	// functions
	// ----------------------------------------------------------------
	function automatic logic [`SBSC_BURST_W-1:0] burst_addr(
		input logic [`SBSC_BURST_W-1:0] start,
		input logic [`SBSC_BURST_W-1:0] cnt,
		input logic                     linear);
		if (linear) begin
			burst_addr = start + cnt;
		end else begin
			burst_addr = start ^ cnt;
		end
	endfunction

	function automatic logic [LANES-1:0] lane_mask(
		input logic             all_n,
		input logic             gate_n,
		input logic [LANES-1:0] lanes_n);
		if (!all_n) begin
			lane_mask = '1;
		end else if (!gate_n) begin
			lane_mask = ~lanes_n;
		end else begin
			lane_mask = '0;
		end
	endfunction

	// ----------------------------------------------------------------
	// cycle decode
	// ----------------------------------------------------------------
	logic                     linear;
	logic                     sleep;
	logic                     load;
	logic                     load_p;
	logic                     desel;
	logic                     step;
	logic                     write_req;
	sbsc_pkg::sbsc_op_t       op;
	logic [LANES-1:0]         wmask;
	logic [`SBSC_BURST_W-1:0] start_nxt;
	logic [`SBSC_BURST_W-1:0] cnt_nxt;
	logic [HI_W-1:0]          hi_nxt;
	logic [AW-1:0]            acc_addr;
	logic                     wb_req;

	assign linear = !st_r.cfg[`SBSC_CFG_LINEAR_N];
	assign sleep  = st_r.cfg[`SBSC_CFG_SLEEP];
	// processor strobe is ignored while deselected
	assign load_p = !ctl.processor_addr_strobe_n && !ctl.chip_select_n;
	assign load   = !sleep && (load_p
		|| (!ctl.cache_ctrl_addr_strobe_n && !ctl.chip_select_n));
	assign desel  = !sleep && !load
		&& !ctl.cache_ctrl_addr_strobe_n && ctl.chip_select_n;
	// output enable plays no part: dummy reads step too
	assign step   = !sleep && !load && !desel
		&& st_r.active && !ctl.burst_step_n;
	assign write_req = !ctl.all_bytes_write_n || !ctl.byte_write_gate_n;

	always_comb begin
		if (sleep) begin
			op = sbsc_pkg::SBSC_OP_NONE;
		end else if (desel) begin
			op = sbsc_pkg::SBSC_OP_DESEL;
		end else if (load_p) begin
			// a processor strobe always opens a read
			op = sbsc_pkg::SBSC_OP_READ;
		end else if (load || st_r.active) begin
			op = write_req ? sbsc_pkg::SBSC_OP_WRITE
				: sbsc_pkg::SBSC_OP_READ;
		end else begin
			op = sbsc_pkg::SBSC_OP_NONE;
		end
	end

	always_comb begin
		wmask = '0;
		if (op == sbsc_pkg::SBSC_OP_WRITE) begin
			wmask = lane_mask(ctl.all_bytes_write_n,
				ctl.byte_write_gate_n, lane_write_n);
		end
	end

	always_comb begin
		start_nxt = st_r.start;
		cnt_nxt   = st_r.cnt;
		hi_nxt    = st_r.hi;
		if (load) begin
			start_nxt = address_low_preset;
			cnt_nxt   = '0;
			hi_nxt    = address_high;
		end else if (step) begin
			cnt_nxt = st_r.cnt + 2'h1;
		end
	end

	// continue cycles use the next address, load cycles the preset
	assign acc_addr = {hi_nxt, burst_addr(start_nxt, cnt_nxt, linear)};

	assign wb_req = wb_cyc_i && wb_stb_i && !st_r.ack;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		st_nxt        = st_r;
		st_nxt.start  = start_nxt;
		st_nxt.cnt    = cnt_nxt;
		st_nxt.hi     = hi_nxt;
		if (load) begin
			st_nxt.active = 1'b1;
		end else if (desel) begin
			st_nxt.active = 1'b0;
		end
		st_nxt.drv1 = (op == sbsc_pkg::SBSC_OP_READ);
		if (op == sbsc_pkg::SBSC_OP_READ) begin
			st_nxt.rd1 = mem[acc_addr];
		end
		st_nxt.rd2 = st_r.rd1;
		// single deselect drops the late stage one cycle early
		if (sleep || op == sbsc_pkg::SBSC_OP_WRITE) begin
			st_nxt.drv2 = 1'b0;
		end else if (op == sbsc_pkg::SBSC_OP_DESEL
			&& st_r.cfg[`SBSC_CFG_SINGLE_DS]) begin
			st_nxt.drv2 = 1'b0;
		end else begin
			st_nxt.drv2 = st_r.drv1;
		end
		st_nxt.ack = wb_req;
		st_nxt.dat = 32'h0;
		if (wb_req && !wb_we_i) begin
			if (wb_adr_i == `SBSC_CFG_OFS) begin
				st_nxt.dat[`SBSC_CFG_W-1:0] = st_r.cfg;
			end else if (wb_adr_i == `SBSC_STAT_OFS) begin
				st_nxt.dat[`SBSC_STAT_BADDR +: `SBSC_BURST_W] =
					burst_addr(st_r.start, st_r.cnt, linear);
				st_nxt.dat[`SBSC_STAT_DRIVE]  = dq_drive(
					st_r.cfg[`SBSC_CFG_FLOW_N], st_r.drv1, st_r.drv2);
				st_nxt.dat[`SBSC_STAT_ACTIVE] = st_r.active;
				st_nxt.dat[`SBSC_STAT_SLEEP]  = sleep;
			end
		end
		if (wb_req && wb_we_i && wb_sel_i[0]
			&& wb_adr_i == `SBSC_CFG_OFS) begin
			st_nxt.cfg = wb_dat_i[`SBSC_CFG_W-1:0];
		end
	end

	// state passed in: a continuous assign only wakes on its arguments
	function automatic logic dq_drive(
		input logic flow_n,
		input logic d1,
		input logic d2);
		dq_drive = flow_n ? d2 : d1;
	endfunction

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			st_r     <= '0;
			st_r.cfg <= `SBSC_CFG_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	// array carries no reset; contents are undefined until written
	always_ff @(posedge clock) begin
		for (int l = 0; l < LANES; l++) begin
			if (wmask[l]) begin
				mem[acc_addr][l*`SBSC_LANE_W +: `SBSC_LANE_W] <=
					dq_i[l*`SBSC_LANE_W +: `SBSC_LANE_W];
			end
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	// enable gating is asynchronous, so dq_oe has a gate after its flop
	assign dq_oe    = {LANES{dq_drive(st_r.cfg[`SBSC_CFG_FLOW_N],
		st_r.drv1, st_r.drv2) && !output_enable_n}};
	assign dq_o     = st_r.cfg[`SBSC_CFG_FLOW_N]
		? st_r.rd2 : st_r.rd1;
	assign wb_dat_o = st_r.dat;
	assign wb_ack_o = st_r.ack;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	property p_load;
		@(posedge clock) disable iff (!rstn)
		load |=> burst_addr(st_r.start, st_r.cnt, linear)
			== $past(address_low_preset);
	endproperty
	a_load: assert property (p_load) else $error("preset not loaded");

	property p_hold;
		@(posedge clock) disable iff (!rstn)
		(!load && ctl.burst_step_n) |=> st_r.cnt == $past(st_r.cnt);
	endproperty
	a_hold: assert property (p_hold) else $error("counter moved");

	property p_linear;
		@(posedge clock) disable iff (!rstn)
		(linear && step) |=> burst_addr(st_r.start, st_r.cnt, 1'b1)
			== $past(st_r.start) + $past(st_r.cnt) + 2'h1;
	endproperty
	a_linear: assert property (p_linear) else $error("linear step");

	property p_inter;
		@(posedge clock) disable iff (!rstn)
		(!linear && step) |=> burst_addr(st_r.start, st_r.cnt, 1'b0)
			== (st_r.start ^ ($past(st_r.cnt) + 2'h1));
	endproperty
	a_inter: assert property (p_inter) else $error("interleave step");

	property p_global;
		@(posedge clock) disable iff (!rstn)
		(op == sbsc_pkg::SBSC_OP_WRITE && !ctl.all_bytes_write_n)
			|-> wmask == '1;
	endproperty
	a_global: assert property (p_global) else $error("global write");

	property p_bytes;
		@(posedge clock) disable iff (!rstn)
		(op == sbsc_pkg::SBSC_OP_WRITE && ctl.all_bytes_write_n)
			|-> wmask == ~lane_write_n;
	endproperty
	a_bytes: assert property (p_bytes) else $error("byte write");

	property p_write_hiz;
		@(posedge clock) disable iff (!rstn)
		op == sbsc_pkg::SBSC_OP_WRITE |=> dq_oe == '0;
	endproperty
	a_write_hiz: assert property (p_write_hiz) else $error("drove on write");

	property p_oe;
		@(posedge clock) disable iff (!rstn)
		output_enable_n |-> dq_oe == '0;
	endproperty
	a_oe: assert property (p_oe) else $error("drivers on with oe high");

	property p_desel_one;
		@(posedge clock) disable iff (!rstn)
		(op == sbsc_pkg::SBSC_OP_DESEL && st_r.cfg[`SBSC_CFG_SINGLE_DS])
			|=> !st_r.drv2;
	endproperty
	a_desel_one: assert property (p_desel_one) else $error("late deselect");

	property p_dcd;
		@(posedge clock) disable iff (!rstn)
		(op == sbsc_pkg::SBSC_OP_DESEL && !st_r.cfg[`SBSC_CFG_SINGLE_DS]
			&& st_r.drv1) |=> st_r.drv2 ##1 !st_r.drv2;
	endproperty
	a_dcd: assert property (p_dcd) else $error("dual deselect wrong");

	property p_sleep;
		@(posedge clock) disable iff (!rstn)
		sleep |=> !st_r.drv1 && !st_r.drv2 && $stable(st_r.cnt);
	endproperty
	a_sleep: assert property (p_sleep) else $error("active in sleep");

	property p_flow;
		@(posedge clock) disable iff (!rstn)
		(op == sbsc_pkg::SBSC_OP_READ && !st_r.cfg[`SBSC_CFG_FLOW_N])
			|=> dq_o == $past(st_nxt.rd1);
	endproperty
	a_flow: assert property (p_flow) else $error("flow-through path");

	// continue cycle from the pins, output enable left free on purpose
	property p_advance;
		@(posedge clock) disable iff (!rstn)
		(!sleep && st_r.active && !ctl.burst_step_n && ctl.chip_select_n
			&& ctl.cache_ctrl_addr_strobe_n)
			|=> st_r.cnt == $past(st_r.cnt) + 2'h1;
	endproperty
	a_advance: assert property (p_advance) else $error("no advance");

	property p_cs_gate;
		@(posedge clock) disable iff (!rstn)
		(ctl.chip_select_n && ctl.cache_ctrl_addr_strobe_n) |-> !load;
	endproperty
	a_cs_gate: assert property (p_cs_gate) else $error("unselected load");

	c_burst: cover property (@(posedge clock) disable iff (!rstn)
		load ##1 step ##1 step ##1 step ##1 step);
	c_dummy: cover property (@(posedge clock) disable iff (!rstn)
		step && output_enable_n && op == sbsc_pkg::SBSC_OP_READ);
	c_bytes: cover property (@(posedge clock) disable iff (!rstn)
		op == sbsc_pkg::SBSC_OP_WRITE && wmask != '0 && wmask != '1);
	c_desel: cover property (@(posedge clock) disable iff (!rstn)
		st_r.drv2 ##1 op == sbsc_pkg::SBSC_OP_DESEL);

endmodule

// ### verification/sbsc_host_model.sv
/*
 host model: processor or cache controller on the sram pins.
 assumes each call starts right after a rising clock edge.
*/
`timescale 1ns/1ps
module sbsc_host_model (
	input  wire logic          clock,
	output sbsc_pkg::sbsc_ctl_t ctl,
	output logic [3:0]         lane_write_n,
	output logic [1:0]         address_low_preset,
	output logic [3:0]         address_high,
	output logic [35:0]        dq_i
);
	// ---------------------------------------------------
	// pin cycles
	// ---------------------------------------------------
	initial begin
		ctl = 6'h3f;
		lane_write_n = 4'hf;
		address_low_preset = 2'h0;
		address_high = 4'h5;
		dq_i = 36'h0;
	end

	// one cycle per call; data flips outside writes so stale data
	// never passes for fresh write data
	task automatic pin(input logic [5:0] c, input logic [3:0] ln,
		input logic [1:0] a, input logic [35:0] d);
		@(posedge clock);
		ctl <= c;
		lane_write_n <= ln;
		address_low_preset <= a;
		if (c[1] & c[0]) begin
			dq_i <= ~dq_i;
		end else begin
			dq_i <= d;
		end
	endtask
endmodule

// ### verification/tb.sv
/*
 self-checking bench for the burst sram control block.
 assumes the host model drives the sram pins; wishbone is driven here.
*/
`timescale 1ns/1ps
module tb;
	// ---------------------------------------------------
	// signals
	// ---------------------------------------------------
	localparam logic [5:0] RD = 6'h17, WALL = 6'h15, WSEL = 6'h16;
	localparam logic [5:0] GB = 6'h14, ST = 6'h3b, ID = 6'h3f;
	localparam logic [5:0] DS = 6'h37, PL = 6'h0f, PX = 6'h2f;
	logic                clock;
	logic                rstn;
	logic                output_enable_n;
	sbsc_pkg::sbsc_ctl_t ctl;
	logic [3:0]          lane_write_n;
	logic [1:0]          address_low_preset;
	logic [3:0]          address_high;
	logic [35:0]         dq_i;
	logic [35:0]         dq_o;
	logic [3:0]          dq_oe;
	logic                wb_cyc_i;
	logic                wb_stb_i;
	logic                wb_we_i;
	logic [7:0]          wb_adr_i;
	logic [3:0]          wb_sel_i;
	logic [31:0]         wb_dat_i;
	logic [31:0]         wb_dat_o;
	logic                wb_ack_o;
	logic [31:0]         rd_q;
	logic [35:0]         wd [4];
	logic [35:0]         ex [4];
	int                  bad_count;
	int                  checked;

	sbsc_host_model hm (.clock(clock), .ctl(ctl),
		.lane_write_n(lane_write_n),
		.address_low_preset(address_low_preset),
		.address_high(address_high), .dq_i(dq_i));

	sbsc_ctrl #(.LANES(4), .HI_W(4)) dut_u (.clock(clock), .rstn(rstn),
		.ctl(ctl), .lane_write_n(lane_write_n),
		.address_low_preset(address_low_preset),
		.address_high(address_high), .output_enable_n(output_enable_n),
		.dq_i(dq_i), .dq_o(dq_o), .dq_oe(dq_oe), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o));

	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end

	// ---------------------------------------------------
	// tasks
	// ---------------------------------------------------
	task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic close_out();
		if (bad_count == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// classic cycle; the wait is bounded so a dead slave ends the run
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [3:0] s, input logic [31:0] d);
		int n;
		@(posedge clock);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_sel_i <= s;
		wb_dat_i <= d;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 16);
		if (wb_ack_o !== 1'b1) begin
			bad_count++;
			close_out();
		end
		rd_q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask

	// read load with all lane enables low, then suspend
	task automatic rd(input logic [1:0] a, input int lag);
		hm.pin(RD, 4'h0, a, 36'h0);
		hm.pin(ID, 4'h0, a, 36'h0);
		repeat (lag) @(posedge clock);
		#1;
	endtask

	// ---------------------------------------------------
	// main sequence
	// ---------------------------------------------------
	initial begin
		rstn = 1'b0;
		output_enable_n = 1'b0;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 8'h00;
		wb_sel_i = 4'h0;
		wb_dat_i = 32'h0;
		bad_count = 0;
		checked = 0;
		wd = '{36'h123456789, 36'h2468ace01, 36'h13579bdf0, 36'h0fedcba98};
		ex = '{wd[0], {wd[1][35:18], 9'h1ff, wd[1][8:0]}, wd[2],
			36'haaaaaaaaa};
		repeat (2) @(posedge clock);
		rstn <= 1'b1;
		wb(1'b0, 8'h00, 4'hf, 32'h0);
		chk(36'(rd_q), 36'h00b);
		wb(1'b1, 8'h00, 4'he, 32'h0);
		wb(1'b1, 8'h08, 4'hf, 32'h0);
		wb(1'b0, 8'h08, 4'hf, 32'h0);
		chk(36'(rd_q), 36'h0);
		wb(1'b0, 8'h00, 4'hf, 32'h0);
		chk(36'(rd_q), 36'h00b);
		for (int o = 0; o < 2; o++) begin
			wb(1'b1, 8'h00, 4'hf, 32'ha + 32'(o));
			for (int p = 0; p < 4; p++) begin
				hm.pin(RD, 4'h0, 2'(p), 36'h0);
				for (int k = 0; k < 5; k++) begin
					if (k > 0) begin
						hm.pin(ST, 4'h0, 2'h0, 36'h0);
					end
					hm.pin(ID, 4'h0, 2'h0, 36'h0);
					wb(1'b0, 8'h04, 4'hf, 32'h0);
					chk(36'(rd_q[1:0]), 36'(o ? p ^ (k % 4) : (p + k) % 4));
				end
			end
		end
		wb(1'b1, 8'h00, 4'hf, 32'hb);
		for (int i = 0; i < 4; i++) begin
			hm.pin(WALL, 4'hf, 2'(i), wd[i]);
		end
		hm.pin(WSEL, 4'hd, 2'h1, 36'hfffffffff);
		#1 chk(36'(dq_oe), 36'h0);
		hm.pin(WSEL, 4'hf, 2'h2, 36'hfffffffff);
		hm.pin(GB, 4'hf, 2'h3, 36'haaaaaaaaa);
		hm.pin(DS, 4'hf, 2'h0, 36'h0);
		for (int i = 0; i < 4; i++) begin
			rd(2'(i), 2);
			chk(dq_o, ex[i]);
			chk(36'(dq_oe), 36'hf);
		end
		@(posedge clock);
		output_enable_n <= 1'b1;
		#1 chk(36'(dq_oe), 36'h0);
		hm.pin(RD, 4'h0, 2'h2, 36'h0);
		hm.pin(ST, 4'h0, 2'h0, 36'h0);
		hm.pin(ID, 4'h0, 2'h0, 36'h0);
		wb(1'b0, 8'h04, 4'hf, 32'h0);
		chk(36'(rd_q[1:0]), 36'h3);
		// four back-to-back steps wrap to the preset on the fifth clock
		hm.pin(RD, 4'h0, 2'h1, 36'h0);
		repeat (4) hm.pin(ST, 4'h0, 2'h0, 36'h0);
		hm.pin(ID, 4'h0, 2'h0, 36'h0);
		wb(1'b0, 8'h04, 4'hf, 32'h0);
		chk(36'(rd_q[1:0]), 36'h1);
		output_enable_n <= 1'b0;
		wb(1'b1, 8'h00, 4'hf, 32'h9);
		hm.pin(DS, 4'h0, 2'h0, 36'h0);
		hm.pin(DS, 4'h0, 2'h0, 36'h0);
		rd(2'h0, 1);
		chk(dq_o, ex[0]);
		chk(36'(dq_oe), 36'hf);
		for (int s = 0; s < 2; s++) begin
			wb(1'b1, 8'h00, 4'hf, s ? 32'h3 : 32'hb);
			rd(2'h0, 2);
			hm.pin(DS, 4'h0, 2'h0, 36'h0);
			hm.pin(DS, 4'h0, 2'h0, 36'h0);
			#1 chk(36'(dq_oe), s ? 36'hf : 36'h0);
			@(posedge clock);
			#1 chk(36'(dq_oe), 36'h0);
		end
		hm.pin(RD, 4'h0, 2'h2, 36'h0);
		hm.pin(PX, 4'h0, 2'h1, 36'h0);
		hm.pin(ID, 4'h0, 2'h0, 36'h0);
		wb(1'b0, 8'h04, 4'hf, 32'h0);
		chk(36'(rd_q[1:0]), 36'h2);
		hm.pin(PL, 4'h0, 2'h1, 36'h0);
		hm.pin(ID, 4'h0, 2'h0, 36'h0);
		wb(1'b0, 8'h04, 4'hf, 32'h0);
		chk(36'(rd_q[1:0]), 36'h1);
		// sleep: loads and steps must leave the counter alone
		wb(1'b1, 8'h00, 4'hf, 32'hf);
		hm.pin(RD, 4'h0, 2'h3, 36'h0);
		hm.pin(ST, 4'h0, 2'h0, 36'h0);
		hm.pin(ID, 4'h0, 2'h0, 36'h0);
		wb(1'b0, 8'h04, 4'hf, 32'h0);
		chk(36'(rd_q[4:0]), 36'h19);
		wb(1'b1, 8'h00, 4'hf, 32'hb);
		wb(1'b0, 8'h04, 4'hf, 32'h0);
		chk(36'(rd_q[4]), 36'h0);
		close_out();
	end
endmodule
